// [core/fieldbus_slave_state_machine.sv]
`timescale 1ns/1ps
`include "slave_sm_defs.svh"

module fieldbus_slave_state_machine
#(
   parameter int IO_W = 32
)
(
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  arst_n_i,
   // State request from the master
   input  wire logic                  req_valid_i,
   input  wire logic [7:0]            req_code_i,
   // Channel setup checks
   input  wire logic                  mbx_chan_ok_i,
   input  wire logic                  pd_chan_ok_i,
   // Firmware download
   input  wire logic                  fw_done_i,
   input  wire logic [15:0]           fw_version_i,
   // Process data
   input  wire logic [IO_W-1:0]       inputs_i,
   input  wire logic [IO_W-1:0]       master_out_i,
   // Status and answer
   output logic [7:0]                 state_code_o,
   output logic                       ack_o,
   output logic                       refuse_o,
   output slave_sm_pkg::service_perm_t perm_o,
   // Process data out
   output logic [IO_W-1:0]            dpm_inputs_o,
   output logic [IO_W-1:0]            outputs_o,
   // Firmware
   output logic                       fw_adopt_o,
   output logic [15:0]                fw_installed_o
);
   import slave_sm_pkg::*;

   // Pin inputs pass two flip-flops as one word; the master holds the code steady with its strobe.
   localparam int SYNC_W = 28 + 2 * IO_W;
   logic [SYNC_W-1:0]     sync1_ff, sync2_ff;
   logic                  req_prev_ff;
   logic                  req_valid_s2_ff, mbx_s2_ff, pd_s2_ff, fw_done_s2_ff;
   logic [7:0]            req_code_s2_ff;
   logic [15:0]           fw_ver_s2_ff;
   logic [IO_W-1:0]       in_s2_ff, mo_s2_ff;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1_ff    <= '0;
         sync2_ff    <= '0;
         req_prev_ff <= 1'b0;
      end
      else
      begin
         sync1_ff    <= {req_valid_i, req_code_i, mbx_chan_ok_i, pd_chan_ok_i, fw_done_i,
                         fw_version_i, inputs_i, master_out_i};
         sync2_ff    <= sync1_ff;
         req_prev_ff <= req_valid_s2_ff;
      end
   end

   assign {req_valid_s2_ff, req_code_s2_ff, mbx_s2_ff, pd_s2_ff, fw_done_s2_ff,
           fw_ver_s2_ff, in_s2_ff, mo_s2_ff} = sync2_ff;

   // A request is a rising level, so a held request is served once.
   logic req_evt;
   assign req_evt = req_valid_s2_ff && !req_prev_ff;

   function automatic logic [7:0] code_of(input slave_state_t s);
      case (s)
         ST_POWER_ON:      code_of = `CODE_POWER_ON;
         ST_CONFIGURING:   code_of = `CODE_CONFIGURING;
         ST_INPUTS_ONLY:   code_of = `CODE_INPUTS_ONLY;
         ST_FULL_EXCHANGE: code_of = `CODE_FULL_EXCHANGE;
         ST_FW_LOAD:       code_of = `CODE_FW_LOAD;
         default:          code_of = `CODE_POWER_ON;
      endcase
   endfunction

   function automatic service_perm_t perm_of(input slave_state_t s);
      service_perm_t p;
      p = '0;
      case (s)
         ST_CONFIGURING:   p = '{mailbox: 1'b1, tunnel: 1'b1, default: 1'b0};
         ST_INPUTS_ONLY:   p = '{mailbox: 1'b1, tunnel: 1'b1, pd_inputs: 1'b1,
                                 default: 1'b0};
         ST_FULL_EXCHANGE: p = '{mailbox: 1'b1, tunnel: 1'b1, pd_inputs: 1'b1,
                                 pd_outputs: 1'b1, default: 1'b0};
         ST_FW_LOAD:       p = '{file_xfer: 1'b1, default: 1'b0};
         default:          p = '0;
      endcase
      return p;
   endfunction

   slave_state_t  state_ff, nxt_state;
   logic [7:0]    state_code_ff, nxt_state_code;
   logic          ack_ff, nxt_ack;
   logic          refuse_ff, nxt_refuse;
   service_perm_t perm_ff, nxt_perm;
   logic [IO_W-1:0] dpm_ff, nxt_dpm;
   logic [IO_W-1:0] out_ff, nxt_out;
   logic          fw_got_ff, nxt_fw_got;
   logic [15:0]   fw_new_ff, nxt_fw_new;
   logic [15:0]   fw_inst_ff, nxt_fw_inst;
   logic          adopt_ff, nxt_adopt;

   always_comb
   begin
      nxt_state   = state_ff;
      nxt_ack     = 1'b0;
      nxt_refuse  = 1'b0;
      nxt_fw_got  = fw_got_ff;
      nxt_fw_new  = fw_new_ff;
      nxt_fw_inst = fw_inst_ff;
      nxt_adopt   = 1'b0;
      if (state_ff == ST_FW_LOAD && fw_done_s2_ff && !fw_got_ff)
      begin
         nxt_fw_got = 1'b1;
         nxt_fw_new = fw_ver_s2_ff;
      end
      if (req_evt)
      begin
         nxt_ack = 1'b1;
         case (state_ff)
            ST_POWER_ON:
            begin
               if (req_code_s2_ff == `CODE_CONFIGURING && mbx_s2_ff)
                  nxt_state = ST_CONFIGURING;
               else if (req_code_s2_ff == `CODE_FW_LOAD)
               begin
                  nxt_state  = ST_FW_LOAD;
                  nxt_fw_got = 1'b0;
               end
               else if (req_code_s2_ff != `CODE_POWER_ON)
               begin
                  nxt_ack    = 1'b0;
                  nxt_refuse = 1'b1;
               end
            end
            ST_CONFIGURING:
            begin
               if (req_code_s2_ff == `CODE_INPUTS_ONLY && pd_s2_ff)
                  nxt_state = ST_INPUTS_ONLY;
               else if (req_code_s2_ff == `CODE_POWER_ON)
                  nxt_state = ST_POWER_ON;
               else if (req_code_s2_ff != `CODE_CONFIGURING)
               begin
                  nxt_ack    = 1'b0;
                  nxt_refuse = 1'b1;
               end
            end
            ST_INPUTS_ONLY, ST_FULL_EXCHANGE:
            begin
               if (req_code_s2_ff == `CODE_FULL_EXCHANGE)
                  nxt_state = ST_FULL_EXCHANGE;
               else if (req_code_s2_ff == `CODE_INPUTS_ONLY)
                  nxt_state = ST_INPUTS_ONLY;
               else if (req_code_s2_ff == `CODE_CONFIGURING)
                  nxt_state = ST_CONFIGURING;
               else if (req_code_s2_ff == `CODE_POWER_ON)
                  nxt_state = ST_POWER_ON;
               else
               begin
                  nxt_ack    = 1'b0;
                  nxt_refuse = 1'b1;
               end
            end
            ST_FW_LOAD:
            begin
               if (req_code_s2_ff == `CODE_POWER_ON)
               begin
                  nxt_state = ST_POWER_ON;
                  // adopt image, only a differing version
                  if (fw_got_ff && fw_new_ff != fw_inst_ff)
                  begin
                     nxt_adopt   = 1'b1;
                     nxt_fw_inst = fw_new_ff;
                  end
                  nxt_fw_got = 1'b0;
               end
               else if (req_code_s2_ff != `CODE_FW_LOAD)
               begin
                  nxt_ack    = 1'b0;
                  nxt_refuse = 1'b1;
               end
            end
            default:
               nxt_state = ST_POWER_ON;
         endcase
      end
      // copy on entry and on every cycle in inputs-only or full exchange, so the snapshot lands with the acknowledge
      if (nxt_state == ST_INPUTS_ONLY || nxt_state == ST_FULL_EXCHANGE)
         nxt_dpm = in_s2_ff;
      else
         nxt_dpm = dpm_ff;
      // outputs follow master data, off from the first cycle outside full exchange
      nxt_out = (nxt_state == ST_FULL_EXCHANGE) ? mo_s2_ff : '0;
      nxt_state_code = code_of(nxt_state);
      nxt_perm       = perm_of(nxt_state);
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_ff      <= ST_POWER_ON;
         state_code_ff <= `CODE_POWER_ON;
         ack_ff        <= 1'b0;
         refuse_ff     <= 1'b0;
         perm_ff       <= '0;
         dpm_ff        <= '0;
         out_ff        <= '0;
         fw_got_ff     <= 1'b0;
         fw_new_ff     <= `RST_VERSION;
         fw_inst_ff    <= `RST_VERSION;
         adopt_ff      <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         state_code_ff <= nxt_state_code;
         ack_ff        <= nxt_ack;
         refuse_ff     <= nxt_refuse;
         perm_ff       <= nxt_perm;
         dpm_ff        <= nxt_dpm;
         out_ff        <= nxt_out;
         fw_got_ff     <= nxt_fw_got;
         fw_new_ff     <= nxt_fw_new;
         fw_inst_ff    <= nxt_fw_inst;
         adopt_ff      <= nxt_adopt;
      end
   end

   assign state_code_o   = state_code_ff;
   assign ack_o          = ack_ff;
   assign refuse_o       = refuse_ff;
   assign perm_o         = perm_ff;
   assign dpm_inputs_o   = dpm_ff;
   assign outputs_o      = out_ff;
   assign fw_adopt_o     = adopt_ff;
   assign fw_installed_o = fw_inst_ff;

   property p_power_on_quiet;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_code_ff == `CODE_POWER_ON |-> !perm_ff.mailbox && !perm_ff.pd_inputs;
   endproperty
   a_power_on_quiet: assert property (p_power_on_quiet)
      else $error("Power-on state permits traffic.");
   property p_config_perm;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_code_ff == `CODE_CONFIGURING |->
         perm_ff.mailbox && perm_ff.tunnel && !perm_ff.pd_inputs && !perm_ff.pd_outputs;
   endproperty
   a_config_perm: assert property (p_config_perm)
      else $error("Configuring permissions wrong.");
   property p_mbx_check;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_ff == ST_POWER_ON && req_evt && !mbx_s2_ff |=> state_ff != ST_CONFIGURING;
   endproperty
   a_mbx_check: assert property (p_mbx_check)
      else $error("Configuring entered without mailbox setup.");
   property p_outputs_off;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_ff == ST_INPUTS_ONLY |-> outputs_o == '0;
   endproperty
   a_outputs_off: assert property (p_outputs_off)
      else $error("Outputs active in inputs-only.");
   property p_pd_check;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_ff == ST_CONFIGURING && req_evt && !pd_s2_ff |=> state_ff != ST_INPUTS_ONLY;
   endproperty
   a_pd_check: assert property (p_pd_check)
      else $error("Inputs-only entered without channel check.");
   property p_snapshot;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      $past(state_ff) == ST_CONFIGURING && state_ff == ST_INPUTS_ONLY |->
         dpm_ff == $past(in_s2_ff) && ack_ff;
   endproperty
   a_snapshot: assert property (p_snapshot)
      else $error("Inputs not copied before acknowledge.");
   property p_fw_entry;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      $changed(state_ff) && state_ff == ST_FW_LOAD |-> $past(state_ff) == ST_POWER_ON;
   endproperty
   a_fw_entry: assert property (p_fw_entry)
      else $error("Firmware load entered from wrong state.");
   property p_fw_perm;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_code_ff == `CODE_FW_LOAD |->
         perm_ff.file_xfer && !perm_ff.mailbox && !perm_ff.tunnel && !perm_ff.pd_inputs;
   endproperty
   a_fw_perm: assert property (p_fw_perm)
      else $error("Firmware load permissions wrong.");
   property p_req_only;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      !req_evt |=> $stable(state_ff);
   endproperty
   a_req_only: assert property (p_req_only)
      else $error("State changed without request.");
   property p_adopt_diff;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      adopt_ff |-> fw_inst_ff != $past(fw_inst_ff) && state_ff == ST_POWER_ON;
   endproperty
   a_adopt_diff: assert property (p_adopt_diff)
      else $error("Image adopted without version change.");
   property p_refuse_hold;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      refuse_ff |-> $stable(state_ff) && !ack_ff;
   endproperty
   a_refuse_hold: assert property (p_refuse_hold)
      else $error("Refused request changed state.");

endmodule

// [core/slave_sm_defs.svh]
`ifndef SLAVE_SM_DEFS_SVH
`define SLAVE_SM_DEFS_SVH

// State codes as presented to the master.
`define CODE_POWER_ON      8'h01
`define CODE_CONFIGURING   8'h02
`define CODE_FW_LOAD       8'h03
`define CODE_INPUTS_ONLY   8'h04
`define CODE_FULL_EXCHANGE 8'h08
// Reset values.
`define RST_VERSION        16'h0000

`endif

// [core/slave_sm_pkg.sv]
package slave_sm_pkg;

   // Gray codes along power-on, configuring, inputs-only, full exchange.
   typedef enum logic [2:0] {
      ST_POWER_ON      = 3'b000,
      ST_CONFIGURING   = 3'b001,
      ST_INPUTS_ONLY   = 3'b011,
      ST_FULL_EXCHANGE = 3'b010,
      ST_FW_LOAD       = 3'b100
   } slave_state_t;

   typedef struct packed {
      logic mailbox;
      logic tunnel;
      logic file_xfer;
      logic pd_inputs;
      logic pd_outputs;
   } service_perm_t;

endpackage

// [verif/fieldbus_master_model.sv]
`timescale 1ns/1ps

module fieldbus_master_model
(
   // Clock
   input  wire logic       clk_sys_i,
   // State request towards the slave
   output logic            req_valid_o,
   output logic [7:0]      req_code_o,
   // Channel setup results
   output logic            mbx_chan_ok_o,
   output logic            pd_chan_ok_o
);
   initial
   begin
      req_valid_o   = 1'b0;
      req_code_o    = 8'h00;
      mbx_chan_ok_o = 1'b0;
      pd_chan_ok_o  = 1'b0;
   end

   task automatic setup(input logic mbx, input logic pd);
      @(posedge clk_sys_i);
      #1;
      mbx_chan_ok_o = mbx;
      pd_chan_ok_o  = pd;
   endtask

   task automatic request(input logic [7:0] code, input int hold);
      @(posedge clk_sys_i);
      #1;
      req_code_o  = code;
      req_valid_o = 1'b1;
      repeat (hold) @(posedge clk_sys_i);
      #1;
      req_valid_o = 1'b0;
      // A released code line must not keep showing the last value.
      req_code_o  = ~code;
      repeat (3) @(posedge clk_sys_i);
   endtask
endmodule

// [verif/test_fieldbus_slave_state_machine.sv]
`timescale 1ns/1ps

module test_fieldbus_slave_state_machine;
   import slave_sm_pkg::*;

   typedef struct {
      logic [7:0]    code;
      logic          refuse;
      service_perm_t perm;
      service_perm_t mask;
   } exp_t;

   logic          clk_sys_i, arst_n_i, req_valid_i, mbx_chan_ok_i, pd_chan_ok_i, fw_done_i;
   logic [7:0]    req_code_i, state_code_o;
   logic [15:0]   fw_version_i, fw_installed_o, ver;
   logic [31:0]   inputs_i, master_out_i, dpm_inputs_o, outputs_o;
   logic          ack_o, refuse_o, fw_adopt_o;
   service_perm_t perm_o;
   logic [7:0]    st;
   logic [7:0]    codes [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08};
   exp_t          exp_q [$];
   int            errors, n_checks, adopt_cnt, seed;

   fieldbus_slave_state_machine #(.IO_W(32)) uut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
      .req_code_i(req_code_i), .mbx_chan_ok_i(mbx_chan_ok_i), .pd_chan_ok_i(pd_chan_ok_i),
      .fw_done_i(fw_done_i), .fw_version_i(fw_version_i), .inputs_i(inputs_i),
      .master_out_i(master_out_i), .state_code_o(state_code_o), .ack_o(ack_o),
      .refuse_o(refuse_o), .perm_o(perm_o), .dpm_inputs_o(dpm_inputs_o),
      .outputs_o(outputs_o), .fw_adopt_o(fw_adopt_o), .fw_installed_o(fw_installed_o));

   fieldbus_master_model master (
      .clk_sys_i(clk_sys_i), .req_valid_o(req_valid_i), .req_code_o(req_code_i),
      .mbx_chan_ok_o(mbx_chan_ok_i), .pd_chan_ok_o(pd_chan_ok_i));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk_ans(input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
         errors++;
      end
   endtask

   task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
         errors++;
      end
   endtask

   // Returns {refuse, next state code} for a request taken in state s.
   // A failed channel check is refused like an undefined transition.
   function automatic logic [8:0] next_of(input logic [7:0] s, c, input logic m, p);
      case (s)
         8'h01: return (c == 8'h04 || c == 8'h08 || (c == 8'h02 && !m)) ? {1'b1, s} :
                       {1'b0, c};
         8'h02: return (c == 8'h03 || c == 8'h08 || (c == 8'h04 && !p)) ? {1'b1, s} :
                       {1'b0, c};
         8'h03: return (c == 8'h01 || c == 8'h03) ? {1'b0, c} : {1'b1, s};
         default: return (c == 8'h03) ? {1'b1, s} : {1'b0, c};
      endcase
   endfunction

   // Permission value and the bits that the state actually pins down.
   function automatic logic [9:0] perm_of(input logic [7:0] s);
      case (s)
         8'h02: return {5'b11000, 5'b11011};
         8'h03: return {5'b00100, 5'b01111};
         8'h04: return {5'b10010, 5'b10011};
         8'h08: return {5'b10011, 5'b10011};
         default: return {5'b00000, 5'b11111};
      endcase
   endfunction

   // An answer with no note queued is spurious and always mismatches.
   always @(posedge clk_sys_i)
   begin
      if (fw_adopt_o === 1'b1)
         adopt_cnt++;
      if (ack_o === 1'b1 || refuse_o === 1'b1)
      begin
         exp_t e;
         if (exp_q.size() > 0)
            e = exp_q.pop_front();
         else
            e = '{8'hFF, 1'b1, 5'h1F, 5'h1F};
         chk_ans({e.code, e.refuse, 2'b00, e.perm}, {state_code_o, refuse_o, 2'b00, perm_o & e.mask});
         if (e.code == 8'h04 && !e.refuse)
            chk_data(inputs_i, dpm_inputs_o);
      end
   end

   task automatic do_reset();
      arst_n_i = 1'b0;
      st = 8'h01;
      repeat (5) @(posedge clk_sys_i);
      #1;
      arst_n_i = 1'b1;
      chk_ans({8'h01, 3'b000, 5'h00}, {state_code_o, ack_o, refuse_o, fw_adopt_o, perm_o});
      chk_data(32'h0, outputs_o);
      chk_ans(16'h0000, fw_installed_o);
   endtask

   task automatic do_req(input logic [7:0] c);
      exp_t       e;
      logic [8:0] r;
      logic [9:0] pm;
      r = next_of(st, c, mbx_chan_ok_i, pd_chan_ok_i);
      pm = perm_of(r[7:0]);
      e = '{r[7:0], r[8], pm[9:5], pm[4:0]};
      exp_q.push_back(e);
      st = r[7:0];
      inputs_i = $random(seed);
      master_out_i = $random(seed);
      master.request(c, 4 + ($random(seed) & 3));
      #1;
      chk_data((st == 8'h08) ? master_out_i : 32'h0, outputs_o);
      if (st == 8'h04 || st == 8'h08)
      begin
         inputs_i = $random(seed);
         repeat (3) @(posedge clk_sys_i);
         #1;
         chk_data(inputs_i, dpm_inputs_o);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #200000;
      errors++;
      close_out();
   end

   initial
   begin
      seed = 25;
      errors = 0;
      n_checks = 0;
      adopt_cnt = 0;
      fw_done_i = 1'b0;
      fw_version_i = 16'h0000;
      inputs_i = 32'h0;
      master_out_i = 32'h0;
      do_reset();
      // With no request, changing the channel checks, firmware and process inputs must not move the state.
      repeat (20)
      begin
         master.setup(1'($random(seed)), 1'($random(seed)));
         fw_done_i = 1'($random(seed));
         inputs_i = $random(seed);
         fw_version_i = 16'($random(seed));
      end
      master.setup(1'b0, 1'b0);
      fw_done_i = 1'b0;
      chk_ans({8'h01, 8'h00}, {state_code_o, 7'h00, ack_o});
      $display("test idle done");
      do_req(8'h04);
      do_req(8'h08);
      do_req(8'h02);
      master.setup(1'b1, 1'b0);
      do_req(8'h02);
      do_req(8'h04);
      master.setup(1'b1, 1'b1);
      do_req(8'h04);
      do_req(8'h08);
      do_req(8'h03);
      $display("test directed done");
      repeat (60)
      begin
         master.setup(($random(seed) & 3) != 0, ($random(seed) & 3) != 0);
         do_req(codes[$unsigned($random(seed)) % 5]);
      end
      chk_ans(16'h0000, adopt_cnt[15:0]);
      $display("test random walk done");
      do_req(8'h01);
      do_req(8'h03);
      ver = {1'b1, 15'($random(seed))};
      fw_version_i = ver;
      fw_done_i = 1'b1;
      do_req(8'h01);
      fw_done_i = 1'b0;
      chk_ans({ver[15:1], 1'b1}, {fw_installed_o[15:1], adopt_cnt == 1});
      do_req(8'h03);
      fw_done_i = 1'b1;
      do_req(8'h01);
      fw_done_i = 1'b0;
      chk_ans({ver[15:1], 1'b1}, {fw_installed_o[15:1], adopt_cnt == 1});
      $display("test firmware done");
      do_reset();
      do_req(8'h02);
      $display("test second reset done");
      repeat (10) @(posedge clk_sys_i);
      chk_ans(16'h0000, 16'(exp_q.size()));
      close_out();
   end
endmodule
